// >>> tb/plug_play_device_info_fields_test.sv
// Self-checking bench for the device information fields.
// Assumes the manager model in ppd_mgr_model.sv and the bound checker.
`timescale 1ns/1ps
module plug_play_device_info_fields_test;
  import ppd_pkg::*;
  logic        clk, reset, req_valid, req_ready, rsp_valid, rsp_ready, owned, uv;
  logic        cfg_maker_wr, cfg_serial_wr;
  logic [31:0] cfg_wdata, unit_maker_product, unit_serial, owner_identifier, id, mk, sn;
  logic [19:0] link_run, port_off_bit;
  ppd_req_t    req, q, own;
  ppd_rsp_t    rsp, r;
  int          error_cnt = 0;
  int          check_count = 0;
  logic [31:0] ca [7] = '{32'h4000, 32'h6000, 32'h8000, 32'hc000, 32'h2, 32'hb, 32'h1234};
  logic [31:0] ro [10] = '{4, 5, 6, 7, 9, 10, 32'h4000, 32'h6000, 32'h8000, 32'hc000};
  ppd_info_fields u_ppd_info_fields (.clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp), .cfg_maker_wr(cfg_maker_wr),
    .cfg_serial_wr(cfg_serial_wr), .cfg_wdata(cfg_wdata), .unit_maker_product(unit_maker_product),
    .unit_serial(unit_serial), .link_run(link_run), .port_off_bit(port_off_bit), .owned(owned),
    .owner_identifier(owner_identifier));
  ppd_mgr_model u_ppd_mgr_model (.clk(clk), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp));
  // ==========================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end
  // ==========================================
  // Helpers
  task automatic test_done();
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  task automatic rnd();
    q.wdata = $urandom;
    q.cmp_data = $urandom;
    q.init_la = 8'($urandom);
    q.src_port = 5'($urandom_range(18, 1));
    q.reply_port = 5'($urandom_range(19, 0));
    q.ra_len = 4'($urandom_range(15, 0)); // Lengths above twelve are cut by the device
    for (int i = 0; i < 12; i++) q.reply_path_bytes[i] = 8'($urandom);
  endtask
  task automatic op(ppd_cmd_t c, logic [31:0] a);
    q.cmd = c;
    q.addr = a;
    u_ppd_mgr_model.xfer(q, r);
  endtask
  // Reply bytes pack big-endian, bytes past the length read zero
  function automatic logic [31:0] ra_word(ppd_req_t o, int w);
    ra_word = '0;
    for (int b = 0; b < 4; b++)
      if (4 * w + b < o.ra_len) ra_word[31 - 8 * b -: 8] = o.reply_path_bytes[4 * w + b];
  endfunction
  function automatic logic [31:0] link_exp(ppd_req_t o, logic [4:0] rp, logic u);
    link_exp = {o.init_la, 2'(((o.ra_len > 12 ? 12 : o.ra_len) + 3) / 4), 1'b0, o.src_port, 3'h0, rp, 1'b1, u,
                1'b0, 5'h13};
  endfunction
  task automatic chk_owner();
    op(ppd_cmd_read, 32'h8);
    chk("owner id", id, r.rdata);
    chk("owned", {31'h0, id != 32'h0}, {31'h0, owned});
    for (int w = 0; w < 3; w++) begin
      op(ppd_cmd_read, 32'(5 + w));
      chk("owner word", ra_word(own, w), r.rdata);
    end
    rnd();
    op(ppd_cmd_read, 32'h4);
    chk("link", link_exp(own, q.reply_port, uv), r.rdata);
  endtask
  task automatic cfgw(logic m, logic [31:0] d);
    cfg_wdata <= d;
    cfg_maker_wr <= m;
    cfg_serial_wr <= !m;
    @(posedge clk);
    {cfg_maker_wr, cfg_serial_wr} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic do_reset(int n);
    reset <= 1'b1;
    repeat (n) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    {own, id, uv} = '0;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(23));
    {reset, cfg_maker_wr, cfg_serial_wr, cfg_wdata, link_run, port_off_bit} = {3'b100, 32'h0, 20'hfffff, 20'h0};
    q = '0;
    do_reset(6);
    chk_owner();
    // Constant, undefined and outside words
    foreach (ca[i]) begin
      op(ppd_cmd_read, ca[i]);
      chk("const", 32'h0, r.rdata);
      chk("const st", 32'h0, {24'h0, r.status});
    end
    for (int c = 0; c < 3; c++) begin
      op(ppd_cmd_t'(c), {16'($urandom_range(65535, 1)), 16'($urandom)});
      chk("outside", 32'hf1, {24'h0, r.status});
    end
    // Refusals, answered slowly so the answer must stand
    u_ppd_mgr_model.stall = 3;
    op(ppd_cmd_write, 32'h8);
    chk("cas only", 32'hf3, {24'h0, r.status});
    foreach (ro[i]) for (int c = 1; c < 3; c++) begin
      op(ppd_cmd_t'(c), ro[i]);
      chk("read only", 32'hf2, {24'h0, r.status});
    end
    u_ppd_mgr_model.stall = 0;
    chk_owner();
    // Unit words: serial alone and a zero maker leave unit valid clear
    sn = $urandom | 32'h1;
    mk = {16'h0, 16'($urandom) | 16'h1};
    cfgw(1'b0, sn);
    cfgw(1'b1, 32'h0);
    chk_owner();
    cfgw(1'b1, mk);
    uv = 1'b1;
    chk("maker out", mk, unit_maker_product);
    op(ppd_cmd_read, 32'h9);
    chk("maker", mk, r.rdata);
    op(ppd_cmd_read, 32'ha);
    chk("serial", sn, r.rdata);
    chk_owner();
    // Claims: matching compare swaps, a wrong compare does not
    repeat (3) begin
      rnd();
      q.cmp_data = id;
      op(ppd_cmd_cas, 32'h8);
      chk("cas old", id, r.rdata);
      own = q;
      id = q.wdata;
      chk("id out", id, owner_identifier);
      chk_owner();
    end
    rnd();
    q.cmp_data = ~id;
    op(ppd_cmd_cas, 32'h8);
    chk("cas miss", id, r.rdata);
    chk_owner();
    // Disabled or dead owner port drops ownership
    port_off_bit <= 20'hfffff;
    @(posedge clk);
    #1 chk("off", 32'h0, {31'h0, owned});
    port_off_bit <= 20'h0;
    link_run[own.src_port] <= 1'b0;
    @(posedge clk);
    #1 chk("dead", 32'h0, {31'h0, owned});
    op(ppd_cmd_read, 32'h8);
    chk("dead id", 32'h0, r.rdata);
    link_run <= 20'hfffff;
    @(posedge clk);
    // Swap to zero releases the owner
    rnd();
    q.cmp_data = id;
    q.wdata = 32'h0;
    op(ppd_cmd_cas, 32'h8);
    own = q;
    id = 32'h0;
    chk_owner();
    // Second reset clears owner and unit state
    do_reset(2);
    chk_owner();
    op(ppd_cmd_read, 32'ha);
    chk("serial rst", 32'h0, r.rdata);
    chk("serial out", 32'h0, unit_serial);
    chk("maker rst", 32'h0, unit_maker_product);
    test_done();
  end
endmodule

// >>> tb/ppd_info_props.sv
// Checker for the device information fields, seen at the top ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module ppd_info_props #(
  parameter int NPORTS = 20
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset,
  // Manager side
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire ppd_pkg::ppd_req_t req,
  input wire logic              rsp_valid,
  input wire logic              rsp_ready,
  input wire ppd_pkg::ppd_rsp_t rsp,
  // Unit writes and ownership
  input wire logic              cfg_serial_wr,
  input wire logic [31:0]       cfg_wdata,
  input wire logic [31:0]       unit_serial,
  input wire logic [NPORTS-1:0] port_off_bit,
  input wire logic              owned,
  input wire logic [31:0]       owner_identifier
);
  import ppd_pkg::*;
  // ==========================================
  // Command sequences
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_op(c, a);
    s_take ##0 (req.cmd == c && req.addr == a);
  endsequence
  // ==========================================
  // Handshake and answers
  a_ready_rule: assert property (req_ready == (!rsp_valid || rsp_ready)) else $error("ready wrong");
  a_answer_next: assert property (s_take |=> rsp_valid) else $error("no answer");
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp)) else $error("answer moved");
  a_outside_code: assert property (s_take ##0 (req.addr[31:16] != 16'h0) |=> rsp == {8'hf1, 32'h0})
    else $error("outside status");
  a_cas_only_wr: assert property (s_op(ppd_cmd_write, 32'h8) |=>
    rsp.status == 8'hf3 && $stable(owner_identifier)) else $error("plain owner write");
  a_read_only: assert property (s_take ##0 (req.cmd != ppd_cmd_read && req.addr inside {[4:7], 9, 10, 32'h4000,
    32'h6000, 32'h8000, 32'hc000}) |=> rsp.status == 8'hf2) else $error("read-only status");
  a_link_fixed: assert property (s_op(ppd_cmd_read, 32'h4) |=>
    rsp.rdata[7] == 1'b1 && rsp.rdata[4:0] == 5'h13 && rsp.rdata[12:8] == $past(req.reply_port)
    && rsp.rdata[21] == 1'b0 && rsp.rdata[15:13] == 3'h0 && rsp.rdata[5] == 1'b0) else $error("link word");
  a_const_zero: assert property (s_take ##0 (req.cmd == ppd_cmd_read && req.addr inside {32'h4000, 32'h6000,
    32'h8000, 32'hc000}) |=> rsp == 40'h0) else $error("const word");
  a_id_cas_only: assert property (!(req_valid && req_ready && req.cmd == ppd_cmd_cas) |=>
    $stable(owner_identifier)) else $error("owner id moved");
  a_zero_unowned: assert property (owner_identifier == 32'h0 |-> !owned) else $error("zero id owned");
  a_off_unowned: assert property (&port_off_bit |-> !owned) else $error("off port owned");
  a_serial_copy: assert property (cfg_serial_wr |=> unit_serial == $past(cfg_wdata)) else $error("serial");
endmodule

bind ppd_info_fields ppd_info_props #(.NPORTS(NPORTS)) u_ppd_info_props (
  .clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
  .rsp_ready(rsp_ready), .rsp(rsp), .cfg_serial_wr(cfg_serial_wr), .cfg_wdata(cfg_wdata),
  .unit_serial(unit_serial), .port_off_bit(port_off_bit), .owned(owned), .owner_identifier(owner_identifier));

// >>> tb/ppd_mgr_model.sv
// Network manager model: issues one command at a time.
// Assumes the bench calls xfer just after a rising edge.
`timescale 1ns/1ps
module ppd_mgr_model (
  // Clock
  input wire logic              clk,
  // Command side
  output logic                  req_valid,
  input wire logic              req_ready,
  output ppd_pkg::ppd_req_t     req,
  // Answer side
  input wire logic              rsp_valid,
  output logic                  rsp_ready,
  input wire ppd_pkg::ppd_rsp_t rsp
);
  import ppd_pkg::*;
  int stall = 0; // Answer stall cycles, set by the bench
  initial begin
    req_valid = 1'b0;
    req = '0;
    rsp_ready = 1'b1;
  end
  // Hold the command until taken; only compare-and-swap claims the owner
  task automatic xfer(input ppd_req_t q, output ppd_rsp_t r);
    logic rd;
    req <= q;
    req_valid <= 1'b1;
    do begin
      @(negedge clk);
      rd = req_ready;
      @(posedge clk);
    end while (!rd);
    req_valid <= 1'b0;
    req <= ~q; // Released lines never keep the old command
    if (stall > 0) begin
      rsp_ready <= 1'b0;
      repeat (stall) @(posedge clk);
      rsp_ready <= 1'b1;
    end
    do begin
      @(negedge clk);
      rd = rsp_valid;
      r = rsp;
      @(posedge clk);
    end while (!rd);
  endtask
endmodule

// >>> verilog/ppd_addr_decode.sv
// Address decoder for the device information fields.
// Purely combinational; the caller registers the outcome.
`timescale 1ns/1ps
`include "ppd_params.svh"
module ppd_addr_decode (
  // Command address
  input  wire logic [31:0]        addr,
  // Decoded field and out-of-service flag
  output ppd_pkg::ppd_field_t     field,
  output logic                    outside
);
  import ppd_pkg::*;

  // Upper bits set means another service or an undefined set
  assign outside = (addr >= `PPD_SVC_LIMIT);

  // Unknown fields inside a set decode to none and answer quietly
  always_comb begin
    case (addr)
      `PPD_OFS_LINK_INFO:     field = ppd_fld_link;
      `PPD_OFS_OWNER_RA_LOW:  field = ppd_fld_ra_low;
      `PPD_OFS_OWNER_RA_MID:  field = ppd_fld_ra_mid;
      `PPD_OFS_OWNER_RA_HIGH: field = ppd_fld_ra_high;
      `PPD_OFS_OWNER_ID:      field = ppd_fld_owner;
      `PPD_OFS_UNIT_MAKER:    field = ppd_fld_unit;
      `PPD_OFS_UNIT_SERIAL:   field = ppd_fld_serial;
      `PPD_OFS_VENDOR_STRLEN: field = ppd_fld_vstr;
      `PPD_OFS_UNIT_ITEM_CODE_STRLEN:   field = ppd_fld_pstr;
      `PPD_OFS_PROTO_COUNT:   field = ppd_fld_pcnt;
      `PPD_OFS_APP_COUNT:     field = ppd_fld_acnt;
      default:                field = ppd_fld_none;
    endcase
  end
endmodule

// >>> verilog/ppd_info_fields.sv
// Plug-and-play device information fields of the router.
// Serves read, write and compare-and-swap commands that the command
// parser has already unpacked, one at a time, and takes unit
// identification writes from the configuration side.
// Assumes all inputs are synchronous to clk.
//
// Summary of operation
// - Link word shows owner initiator logical address
// - Link word counts valid owner reply words
// - Link word shows port that set owner
// - Link word shows reply port of read
// - Device type bit always reads one
// - Unit valid clears at reset, sets on nonzero
// - Link word shows fixed router port total
// - First owner word holds reply bytes 0-3
// - Second owner word holds reply bytes 4-7
// - Third owner word holds reply bytes 8-11
// - Zero identifier or reset means no owner
// - Dead or disabled owner port means no owner
// - Owner identifier changes only by compare-and-swap
// - Unit maker word read-only to manager
// - Unit serial read-only to manager
// - Vendor string size reads zero
// - Product string size reads zero
// - Protocol total reads zero
// - Application total reads zero
// - Outside address answers invalid-address status
// - Plain write to owner identifier refused
// - Write to read-only field refused
`timescale 1ns/1ps
`include "ppd_params.svh"
module ppd_info_fields #(
  parameter int NPORTS = 20
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // Manager command port
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire ppd_pkg::ppd_req_t     req,
  // Manager answer port
  output logic                       rsp_valid,
  input  wire logic                  rsp_ready,
  output ppd_pkg::ppd_rsp_t          rsp,
  // Configuration-side unit writes
  input  wire logic                  cfg_maker_wr,
  input  wire logic                  cfg_serial_wr,
  input  wire logic [31:0]           cfg_wdata,
  output logic [31:0]                unit_maker_product,
  output logic [31:0]                unit_serial,
  // Port state from the router
  input  wire logic [NPORTS-1:0]     link_run,
  input  wire logic [NPORTS-1:0]     port_off_bit,
  // Ownership state
  output logic                       owned,
  output logic [31:0]                owner_identifier
);
  import ppd_pkg::*;

  // ==========================================
  // Elaboration checks

  // Port numbers are five bits wide, so more than 32 ports cannot be named
  if (NPORTS < 1 || NPORTS > 32) begin : g_nports_check
    $error("ppd_info_fields: NPORTS out of range");
  end

  // ==========================================
  // Functions

  // One owner word: bytes at or beyond the captured length read zero,
  // so a short reply path never leaks stale bytes of an older owner
  function automatic logic [31:0] ra_word(input logic [11:0][7:0] bytes,
                                          input logic [3:0]       len,
                                          input logic [1:0]       idx);
    logic [31:0] w;
    logic [3:0]  b;
    w = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      b = 4'(idx * 4 + i);
      if (b < len) begin
        w[31-8*i -: 8] = bytes[b];
      end
    end
    return w;
  endfunction

  // Number of owner words that hold any captured byte
  function automatic logic [1:0] word_count(input logic [3:0] len);
    if (len == 4'h0) begin
      return 2'd0;
    end else if (len <= 4'h4) begin
      return 2'd1;
    end else if (len <= 4'h8) begin
      return 2'd2;
    end
    return 2'd3;
  endfunction

  // ==========================================
  // State

  logic [31:0]       owner_id_reg;
  logic [7:0]        owner_la_reg;
  logic [4:0]        owner_port_reg;
  logic [3:0]        ra_len_reg;
  logic [11:0][7:0]  ra_bytes_reg;
  logic [31:0]       unit_maker_reg;
  logic [31:0]       unit_serial_reg;
  logic              unit_valid_reg;
  logic              rsp_valid_reg;
  ppd_rsp_t          rsp_reg;
  ppd_rsp_t          rsp_next;

  ppd_field_t        field;
  logic              outside;
  logic              take;
  logic              owned_now;
  logic [31:0]       eff_id;
  logic              cas_hit;
  logic [3:0]        cap_len;
  ppd_link_info_t    link_word;

  // ==========================================
  // Decode and ownership

  ppd_addr_decode u_decode (
    .addr    (req.addr),
    .field   (field),
    .outside (outside)
  );

  ppd_owner_check #(
    .NPORTS (NPORTS)
  ) u_owner (
    .owner_identifier  (owner_id_reg),
    .owner_port_number (owner_port_reg),
    .link_run          (link_run),
    .port_off_bit      (port_off_bit),
    .owned             (owned_now)
  );

  // Back-pressure: a new command waits until the last answer is taken
  assign req_ready = !rsp_valid_reg || rsp_ready;
  assign take      = req_valid && req_ready;

  // An unowned router compares and reads as identifier zero
  assign eff_id  = owned_now ? owner_id_reg : 32'h0000_0000;

  // Only a matching compare-and-swap to the identifier changes it
  assign cas_hit = take && !outside && req.cmd == ppd_cmd_cas
                   && field == ppd_fld_owner && req.cmp_data == eff_id;

  // Paths longer than the three owner words are cut to twelve bytes
  assign cap_len = (req.ra_len > `PPD_RA_MAX_BYTES) ? `PPD_RA_MAX_BYTES : req.ra_len;

  // ==========================================
  // Link-information word

  always_comb begin
    link_word                         = '0;
    link_word.owner_initiator_address = owner_la_reg;
    link_word.owner_word_count        = word_count(ra_len_reg);
    link_word.owner_port_number       = owner_port_reg;
    link_word.reply_port_number       = req.reply_port;
    link_word.dev_type                = `PPD_DEV_IS_ROUTER;
    link_word.unit_valid              = unit_valid_reg;
    link_word.port_total              = `PPD_PORT_TOTAL;
  end

  // ==========================================
  // Answer selection

  // Status first, then data; refused commands return zero data
  always_comb begin
    rsp_next.status = `PPD_ST_OK;
    rsp_next.rdata  = 32'h0000_0000;
    if (outside) begin
      rsp_next.status = `PPD_ST_BAD_ADDR;
    end else if (req.cmd == ppd_cmd_write && field == ppd_fld_owner) begin
      rsp_next.status = `PPD_ST_CAS_ONLY;
    end else if (req.cmd != ppd_cmd_read && field != ppd_fld_owner && field != ppd_fld_none) begin
      rsp_next.status = `PPD_ST_READ_ONLY;
    end else begin
      case (field)
        ppd_fld_link:    rsp_next.rdata = link_word;
        ppd_fld_ra_low:  rsp_next.rdata = ra_word(ra_bytes_reg, ra_len_reg, 2'd0);
        ppd_fld_ra_mid:  rsp_next.rdata = ra_word(ra_bytes_reg, ra_len_reg, 2'd1);
        ppd_fld_ra_high: rsp_next.rdata = ra_word(ra_bytes_reg, ra_len_reg, 2'd2);
        ppd_fld_owner:   rsp_next.rdata = eff_id;
        ppd_fld_unit:    rsp_next.rdata = unit_maker_reg;
        ppd_fld_serial:  rsp_next.rdata = unit_serial_reg;
        ppd_fld_vstr:    rsp_next.rdata = {17'h0_0000, `PPD_STRING_SIZE};
        ppd_fld_pstr:    rsp_next.rdata = {17'h0_0000, `PPD_STRING_SIZE};
        ppd_fld_pcnt:    rsp_next.rdata = {27'h000_0000, `PPD_PROTOCOL_TOTAL};
        ppd_fld_acnt:    rsp_next.rdata = {24'h00_0000, `PPD_APPLICATION_TOTAL};
        default:         rsp_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================
  // Answer registers

  // Answer stands until the parser takes it
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_valid_reg <= 1'b0;
    end else if (take) begin
      rsp_valid_reg <= 1'b1;
    end else if (rsp_ready) begin
      rsp_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_reg <= '0;
    end else if (take) begin
      rsp_reg <= rsp_next;
    end
  end

  assign rsp_valid = rsp_valid_reg;
  assign rsp       = rsp_reg;

  // ==========================================
  // Owner record

  // Identifier itself; a swap to zero gives the router up
  always_ff @(posedge clk) begin
    if (reset) begin
      owner_id_reg <= `PPD_WORD_RESET;
    end else if (cas_hit) begin
      owner_id_reg <= req.wdata;
    end
  end

  // Who set it, from where, and how to answer them
  always_ff @(posedge clk) begin
    if (reset) begin
      owner_la_reg   <= 8'h00;
      owner_port_reg <= 5'h00;
      ra_len_reg     <= 4'h0;
      ra_bytes_reg   <= '0;
    end else if (cas_hit) begin
      owner_la_reg   <= req.init_la;
      owner_port_reg <= req.src_port;
      ra_len_reg     <= cap_len;
      ra_bytes_reg   <= req.reply_path_bytes;
    end
  end

  // ==========================================
  // Unit identification

  // Writable only from the configuration side, never by the manager
  always_ff @(posedge clk) begin
    if (reset) begin
      unit_maker_reg <= `PPD_WORD_RESET;
    end else if (cfg_maker_wr) begin
      unit_maker_reg <= cfg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      unit_serial_reg <= `PPD_WORD_RESET;
    end else if (cfg_serial_wr) begin
      unit_serial_reg <= cfg_wdata;
    end
  end

  // Sticky once set; a later zero write does not clear it
  always_ff @(posedge clk) begin
    if (reset) begin
      unit_valid_reg <= 1'b0;
    end else if (cfg_maker_wr && (cfg_wdata[31:16] != 16'h0000 || cfg_wdata[15:0] != 16'h0000)) begin
      unit_valid_reg <= 1'b1;
    end
  end

  // ==========================================
  // Outputs

  assign unit_maker_product = unit_maker_reg;
  assign unit_serial        = unit_serial_reg;
  assign owned              = owned_now;
  assign owner_identifier   = owner_id_reg;

endmodule

// >>> verilog/ppd_owner_check.sv
// Decides whether the router currently has an owner.
// Assumes link_run is already synchronous to clk and that the
// surroundings hold link_run high for the internal ports.
`timescale 1ns/1ps
module ppd_owner_check #(
  parameter int NPORTS = 20
) (
  // Recorded owner
  input  wire logic [31:0]       owner_identifier,
  input  wire logic [4:0]        owner_port_number,
  // Port state
  input  wire logic [NPORTS-1:0] link_run,
  input  wire logic [NPORTS-1:0] port_off_bit,
  // Result
  output logic                   owned
);

  // The owner port is a five-bit index into these vectors
  if (NPORTS < 1 || NPORTS > 32) begin : g_nports_check
    $error("ppd_owner_check: NPORTS out of range");
  end

  // A zero identifier or a dead or disabled owner port means no owner
  always_comb begin
    owned = 1'b0;
    if (owner_identifier != 32'h0000_0000 && 32'(owner_port_number) < NPORTS) begin
      owned = link_run[owner_port_number] && !port_off_bit[owner_port_number];
    end
  end
endmodule

// >>> verilog/ppd_params.svh
// Constants for the plug-and-play device information fields.
// Assumes a single core clock and full-word accesses.
`ifndef PPD_PARAMS_SVH
`define PPD_PARAMS_SVH

// ==========================================
// Field offsets (word addresses)
`define PPD_OFS_LINK_INFO     32'h0000_0004
`define PPD_OFS_OWNER_RA_LOW  32'h0000_0005
`define PPD_OFS_OWNER_RA_MID  32'h0000_0006
`define PPD_OFS_OWNER_RA_HIGH 32'h0000_0007
`define PPD_OFS_OWNER_ID      32'h0000_0008
`define PPD_OFS_UNIT_MAKER    32'h0000_0009
`define PPD_OFS_UNIT_SERIAL   32'h0000_000a
`define PPD_OFS_VENDOR_STRLEN 32'h0000_4000
`define PPD_OFS_UNIT_ITEM_CODE_STRLEN   32'h0000_6000
`define PPD_OFS_PROTO_COUNT   32'h0000_8000
`define PPD_OFS_APP_COUNT     32'h0000_c000
// Addresses at or above this lie outside the service
`define PPD_SVC_LIMIT         32'h0001_0000

// ==========================================
// Field values and reset values
`define PPD_PORT_TOTAL        5'h13
`define PPD_DEV_IS_ROUTER     1'b1
`define PPD_WORD_RESET        32'h0000_0000
`define PPD_STRING_SIZE       15'h0000
`define PPD_PROTOCOL_TOTAL    5'h00
`define PPD_APPLICATION_TOTAL 8'h00
`define PPD_RA_MAX_BYTES      4'hc

// ==========================================
// Reply status codes
`define PPD_ST_OK             8'h00
`define PPD_ST_BAD_ADDR       8'hf1
`define PPD_ST_READ_ONLY      8'hf2
`define PPD_ST_CAS_ONLY       8'hf3

`endif

// >>> verilog/ppd_pkg.sv
// Types shared by the plug-and-play device information fields.
// Constants live in ppd_params.svh.
package ppd_pkg;

  typedef enum logic [1:0] {ppd_cmd_read, ppd_cmd_write, ppd_cmd_cas} ppd_cmd_t;

  typedef enum logic [3:0] {
    ppd_fld_none, ppd_fld_link, ppd_fld_ra_low, ppd_fld_ra_mid, ppd_fld_ra_high,
    ppd_fld_owner, ppd_fld_unit, ppd_fld_serial, ppd_fld_vstr, ppd_fld_pstr,
    ppd_fld_pcnt, ppd_fld_acnt
  } ppd_field_t;

  // One command from the network manager
  typedef struct packed {
    ppd_cmd_t        cmd;
    logic [31:0]     addr;
    logic [31:0]     wdata;
    logic [31:0]     cmp_data;
    logic [7:0]      init_la;
    logic [4:0]      src_port;
    logic [4:0]      reply_port;
    logic [3:0]      ra_len;
    logic [11:0][7:0] reply_path_bytes;
  } ppd_req_t;

  // Answer: status code and read data (old value for compare-and-swap)
  typedef struct packed {
    logic [7:0]  status;
    logic [31:0] rdata;
  } ppd_rsp_t;

  // Link-information word layout
  typedef struct packed {
    logic [7:0] owner_initiator_address;
    logic [1:0] owner_word_count;
    logic       rsv21;
    logic [4:0] owner_port_number;
    logic [2:0] rsv15;
    logic [4:0] reply_port_number;
    logic       dev_type;
    logic       unit_valid;
    logic       rsv5;
    logic [4:0] port_total;
  } ppd_link_info_t;

endpackage
